// >>> iso_input_port.sv
// Summary of operation
// - decode eight bytes at aligned base
// - offset 1 reads inputs 0-7; write clears irq
// - offset 5 reads inputs 8-15; writes ignored
// - bit n holds lowest input plus n
// - energized reads zero, de-energized reads one
// - enabled irq fires on any input change
// - read of offset 2 enables irq
// - write to offset 2 disables irq
// - irq drives one selected line only
// - response 10 us, or 4.7 ms filtered
// - per-channel static filter selection
// - A9..A3 match base, A2..A0 select
`timescale 1ns/1ps
`default_nettype none
module iso_input_port (
	input  wire logic                                    I_CLOCK,    // 100 MHz clock
	input  wire logic                                    I_RSTN,     // async reset, low
	input  wire logic [iso_input_pkg::ADDR_W-1:0]        I_ADDR,     // host address A9..A0
	input  wire logic                                    I_RD,       // read strobe, one cycle
	input  wire logic                                    I_WR,       // write strobe, one cycle
	input  wire logic [iso_input_pkg::BASE_W-1:0]        I_BASE,     // base jumpers A9..A3
	input  wire logic [iso_input_pkg::NUM_INPUTS-1:0]    I_INPUTS,   // field levels, high on
	input  wire logic [iso_input_pkg::NUM_INPUTS-1:0]    I_SLOW_SEL, // per channel filter
	input  wire logic [iso_input_pkg::IRQ_LINES-1:0]     I_IRQ_SEL,  // one-hot line jumper
	output logic      [iso_input_pkg::DATA_W-1:0]        O_DATA,     // read data
	output logic                                         O_DATA_OE,  // drive data bus
	output logic      [iso_input_pkg::IRQ_LINES-1:0]     O_IRQ       // interrupt lines
);
	// timing at a glance
	// - strobes are one clock long and come from logic on this clock
	// - a read taken at an edge is answered in the following cycle
	// - data and drive stand for that one cycle only, then go idle
	// - enable and disable already gate a change in the strobe cycle; clear acts from the cycle after
	// - a filtered change reaches the interrupt one edge later
	// - fast channels settle in about one thousand cycles
	// - slow channels take hundreds of thousands of cycles
	// - change detect compares the whole filtered word with last cycle
	// - several channels changing together raise one request
	// - reading the input bytes never clears the request
	// - disable drops a pending request as well
	// limitations
	// - base, filter and line jumpers are treated as static levels
	// - two line jumpers at once: only the lowest line is driven
	// - write data is never looked at, every write is a strobe
	// - read and write strobes are never high together
	// trade-offs
	// - registered outputs cost one cycle of read latency
	// - the first cycle after reset never reports a change,
	//   so the reset level of the filters cannot raise a request

	// two byte lanes of readback
	localparam int unsigned LANES = iso_input_pkg::NUM_INPUTS / iso_input_pkg::DATA_W;

	typedef struct packed {
		logic [iso_input_pkg::NUM_INPUTS-1:0] last;
		logic                                 primed;
		logic                                 irq_en;
		logic                                 irq_pend;
		logic [iso_input_pkg::DATA_W-1:0]     data;
		logic                                 data_oe;
		logic [iso_input_pkg::IRQ_LINES-1:0]  irq;
	} port_state_t;

	port_state_t                          st_reg;
	port_state_t                          st_next;
	iso_input_pkg::host_req_t             req;
	logic [iso_input_pkg::NUM_INPUTS-1:0] field;
	logic                                 hit;
	logic [iso_input_pkg::SEL_W-1:0]      sel;
	logic                                 changed;
	logic [iso_input_pkg::DATA_W-1:0]     lane_byte [LANES];
	logic [iso_input_pkg::IRQ_LINES-1:0]  line_pick;
	logic                                 rd_hit;
	logic                                 wr_hit;

	// true when a strobe hits the given register of the window
	function automatic logic reg_hit(
		input logic                            strobe,
		input logic                            in_window,
		input logic [iso_input_pkg::SEL_W-1:0] offset,
		input logic [iso_input_pkg::SEL_W-1:0] target
	);
		return strobe && in_window && (offset == target);
	endfunction

	// keep only the lowest jumper so at most one line is ever driven
	function automatic logic [iso_input_pkg::IRQ_LINES-1:0] lowest_line(
		input logic [iso_input_pkg::IRQ_LINES-1:0] jumpers
	);
		logic [iso_input_pkg::IRQ_LINES-1:0] pick;
		pick = '0;
		for (int i = iso_input_pkg::IRQ_LINES - 1; i >= 0; i--) begin
			if (jumpers[i]) begin
				pick    = '0;
				pick[i] = 1'b1;
			end
		end
		return pick;
	endfunction

	// readback value for one offset; unused offsets give the filler
	function automatic logic [iso_input_pkg::DATA_W-1:0] read_value(
		input logic [iso_input_pkg::SEL_W-1:0]  offset,
		input logic [iso_input_pkg::DATA_W-1:0] low_byte,
		input logic [iso_input_pkg::DATA_W-1:0] high_byte
	);
		logic [iso_input_pkg::DATA_W-1:0] value;
		value = iso_input_pkg::READ_FILLER;
		if (offset == iso_input_pkg::OFS_INPUT_LOW_BYTE_AND_IRQ_CLEAR) begin
			value = low_byte;
		end else if (offset == iso_input_pkg::OFS_INPUT_HIGH_BYTE) begin
			value = high_byte;
		end
		return value;
	endfunction

	// set beats clear: a counted change in the clearing cycle is never lost
	function automatic logic pend_update(
		input logic pend,
		input logic clear,
		input logic raise
	);
		logic result;
		result = pend;
		if (clear) begin
			result = 1'b0;
		end
		if (raise) begin
			result = 1'b1;
		end
		return result;
	endfunction

	// one filter per channel, each with its own jumper
	genvar g;
	generate
		for (g = 0; g < iso_input_pkg::NUM_INPUTS; g++) begin : g_chan
			iso_input_filter u_filt (
				.i_clock (I_CLOCK),
				.i_rstn  (I_RSTN),
				.i_pin   (I_INPUTS[g]),
				.i_slow  (I_SLOW_SEL[g]),
				.o_state (field[g])
			);
		end
	endgenerate

	// address decode against the jumpered base
	assign req     = '{addr: I_ADDR, rd: I_RD, wr: I_WR};
	assign hit     = req.addr[iso_input_pkg::ADDR_W-1:iso_input_pkg::BASE_LSB] == I_BASE;
	assign sel     = req.addr[iso_input_pkg::BASE_LSB-1:iso_input_pkg::SEL_LSB];
	assign changed = st_reg.primed && (field != st_reg.last);
	// qualified strobes
	assign rd_hit  = hit && req.rd;
	assign wr_hit  = hit && req.wr;
	// no jumper means no line driven
	assign line_pick = lowest_line(I_IRQ_SEL);

	// readback lanes: lane k carries inputs 8k..8k+7, inverted
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			assign lane_byte[g] =
				~field[g*iso_input_pkg::DATA_W +: iso_input_pkg::DATA_W];
		end
	endgenerate

	// register map, interrupt state and output drive
	always_comb begin
		logic clear_req;
		logic raise_req;
		clear_req       = 1'b0;
		raise_req       = 1'b0;
		st_next         = st_reg;
		st_next.last    = field;
		st_next.primed  = 1'b1; // first compare waits a cycle after reset
		st_next.data_oe = rd_hit;
		st_next.data    = iso_input_pkg::READ_FILLER;

		// input bytes at offsets 1 and 5, filler elsewhere
		if (rd_hit) begin
			st_next.data = read_value(sel, lane_byte[0], lane_byte[LANES-1]);
		end
		// a read at offset 2 turns the interrupt on
		if (reg_hit(req.rd, hit, sel, iso_input_pkg::OFS_IRQ_ENABLE_DISABLE_STROBE)) begin
			st_next.irq_en = 1'b1;
		end

		// a write at offset 2 turns it off
		if (reg_hit(req.wr, hit, sel, iso_input_pkg::OFS_IRQ_ENABLE_DISABLE_STROBE)) begin
			st_next.irq_en = 1'b0;
		end
		// writes at 1 or 2 drop the request; offset 5 and the rest do nothing
		clear_req = reg_hit(req.wr, hit, sel, iso_input_pkg::OFS_INPUT_LOW_BYTE_AND_IRQ_CLEAR)
			|| reg_hit(req.wr, hit, sel, iso_input_pkg::OFS_IRQ_ENABLE_DISABLE_STROBE);

		// a change only counts while enabled after this cycle's strobes
		raise_req = changed && st_next.irq_en;
		// held until cleared or disabled
		st_next.irq_pend = pend_update(st_reg.irq_pend, clear_req, raise_req);

		// drive only the picked line
		st_next.irq = st_next.irq_pend ? line_pick : '0;
	end

	// state register; reset leaves irq off and read data at zero
	always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// every output straight from the state register
	assign O_DATA    = st_reg.data;
	assign O_DATA_OE = st_reg.data_oe;
	assign O_IRQ     = st_reg.irq;
endmodule // iso_input_port
`default_nettype wire

// >>> iso_input_pkg.sv
package iso_input_pkg;

	// host address decode
	localparam int unsigned ADDR_W      = 10;
	localparam int unsigned SEL_W       = 3;
	localparam int unsigned BASE_W      = 7;
	localparam int unsigned SEL_LSB     = 0;
	localparam int unsigned BASE_LSB    = 3;
	localparam int unsigned DATA_W      = 8;
	localparam int unsigned NUM_INPUTS  = 16;

	// register offsets within the eight-byte window
	localparam logic [2:0] OFS_INPUT_LOW_BYTE_AND_IRQ_CLEAR = 3'h1;
	localparam logic [2:0] OFS_IRQ_ENABLE_DISABLE_STROBE    = 3'h2;
	localparam logic [2:0] OFS_INPUT_HIGH_BYTE              = 3'h5;

	// filler data returned at unused offsets
	localparam logic [7:0] READ_FILLER = 8'hff;

	// input response times
	localparam int unsigned CLOCK_HZ       = 100_000_000;
	localparam int unsigned FAST_RESP_NS   = 10_000;
	localparam int unsigned SLOW_RESP_US   = 4_700;
	localparam int unsigned FAST_CYCLES    = FAST_RESP_NS / 10;
	localparam int unsigned SLOW_CYCLES    = SLOW_RESP_US * (CLOCK_HZ / 1_000_000);
	localparam int unsigned FILT_CNT_W     = 20;

	// interrupt line selection, one-hot over the eleven legal lines
	localparam int unsigned IRQ_LINES      = 11;

	// host bus strobes travel together
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              rd;
		logic              wr;
	} host_req_t;

	// per channel filter state
	typedef struct packed {
		logic [2:0]            sync;
		logic                  state;
		logic [FILT_CNT_W-1:0] cnt;
	} filt_state_t;

endpackage

// >>> iso_input_filter.sv
`timescale 1ns/1ps
`default_nettype none
module iso_input_filter #(
	parameter int unsigned FAST_LIMIT = iso_input_pkg::FAST_CYCLES,
	parameter int unsigned SLOW_LIMIT = iso_input_pkg::SLOW_CYCLES
) (
	input  wire logic i_clock,  // system clock
	input  wire logic i_rstn,   // async reset, active low
	input  wire logic i_pin,    // raw field level, energized high
	input  wire logic i_slow,   // static slow filter select
	output logic      o_state   // filtered field level
);
	iso_input_pkg::filt_state_t s_reg;
	iso_input_pkg::filt_state_t s_next;
	logic [iso_input_pkg::FILT_CNT_W-1:0] limit;

	// pick the settle time for this channel
	assign limit = i_slow ? iso_input_pkg::FILT_CNT_W'(SLOW_LIMIT)
	                      : iso_input_pkg::FILT_CNT_W'(FAST_LIMIT);

	// three-stage sync, then level must hold steady for the whole settle time
	always_comb begin
		s_next      = s_reg;
		s_next.sync = {s_reg.sync[1:0], i_pin};
		if (s_reg.sync[2] != s_reg.sync[1]) begin
			s_next.cnt = '0; // stages disagree: still moving
		end else if (s_reg.sync[2] == s_reg.state) begin
			s_next.cnt = '0;
		end else if (s_reg.cnt >= limit - 1'b1) begin
			s_next.state = s_reg.sync[2];
			s_next.cnt   = '0;
		end else begin
			s_next.cnt = s_reg.cnt + 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_state = s_reg.state;
endmodule // iso_input_filter
`default_nettype wire

// >>> iso_input_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module iso_input_port_chk (
	input wire logic        I_CLOCK,   // clk
	input wire logic        I_RSTN,    // rst
	input wire logic [9:0]  I_ADDR,    // addr
	input wire logic        I_RD,      // rd
	input wire logic        I_WR,      // wr
	input wire logic [6:0]  I_BASE,    // base
	input wire logic [10:0] I_IRQ_SEL, // line
	input wire logic [7:0]  O_DATA,    // data
	input wire logic        O_DATA_OE, // drive
	input wire logic [10:0] O_IRQ      // irq
);
	// decode shared by all properties
	wire hit = I_ADDR[9:3] == I_BASE;
	wire [2:0] ofs = I_ADDR[2:0];
	wire pend = |O_IRQ;
	wire clr = I_WR && hit && ofs inside {3'h1, 3'h2};
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (!I_RSTN);
	chk_oe_hit: assert property (I_RD && hit |=> O_DATA_OE)
		else $error("no drive");
	chk_oe_miss: assert property (!(I_RD && hit) |=> !O_DATA_OE)
		else $error("stray drive");
	chk_fill_unused: assert property (I_RD && hit && ofs inside {3'h0, 3'h3, 3'h4, 3'h6, 3'h7}
		|=> O_DATA == 8'hff) else $error("bad filler");
	chk_en_fill: assert property (I_RD && hit && ofs == 3'h2 |=> O_DATA == 8'hff)
		else $error("bad enable data");
	chk_irq_line: assert property (!pend || O_IRQ == I_IRQ_SEL)
		else $error("wrong line");
	chk_irq_off: assert property (I_WR && hit && ofs == 3'h2 |=> ##1 !pend [*2])
		else $error("irq on");
	chk_irq_fall: assert property ($fell(pend) |-> $past(clr))
		else $error("irq dropped");
	chk_irq_keep: assert property (pend && !clr && !$past(clr) |=> pend)
		else $error("irq lost");
	// a clear seen, a raise seen, a high byte read seen
	cov_clear: cover property (clr && pend);
	cov_raise: cover property ($rose(pend));
	cov_read: cover property (I_RD && hit && ofs == 3'h5);
endmodule // iso_input_port_chk
bind iso_input_port iso_input_port_chk chk_u (.I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN),
	.I_ADDR(I_ADDR), .I_RD(I_RD), .I_WR(I_WR), .I_BASE(I_BASE), .I_IRQ_SEL(I_IRQ_SEL),
	.O_DATA(O_DATA), .O_DATA_OE(O_DATA_OE), .O_IRQ(O_IRQ));
`default_nettype wire

// >>> iso_host.sv
`timescale 1ns/1ps
`default_nettype none
module iso_host (
	input  wire logic       i_clock, // bus clock
	output logic      [9:0] o_addr = '0, // address
	output logic            o_rd = 1'b0, // read
	output logic            o_wr = 1'b0  // write
);
	// one strobe held to its sampling edge; answer stands just after that edge
	task automatic acc(input logic [9:0] a, input logic w);
		@(posedge i_clock);
		o_addr <= a;
		o_rd <= !w;
		o_wr <= w;
		@(posedge i_clock);
		o_rd <= 1'b0;
		o_wr <= 1'b0;
		o_addr <= ~a; // idle bus must not keep the old address
		#1;
	endtask
endmodule // iso_host
`default_nettype wire

// >>> iso_input_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module iso_input_port_test;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [6:0]  base = 7'h60;
	logic [15:0] ins = 16'h0000;
	logic [15:0] slow = 16'h0000;
	logic [10:0] sel = 11'h001;
	logic [9:0]  addr;
	logic        rd, wr, oe;
	logic [7:0]  data;
	logic [10:0] irq;
	int          n_fail = 0, n_compared = 0, cyc = 0;
	iso_host host_u (.i_clock(clk), .o_addr(addr), .o_rd(rd), .o_wr(wr));
	iso_input_port dut_u (.I_CLOCK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_RD(rd),
		.I_WR(wr), .I_BASE(base), .I_INPUTS(ins), .I_SLOW_SEL(slow),
		.I_IRQ_SEL(sel), .O_DATA(data), .O_DATA_OE(oe), .O_IRQ(irq));
	initial forever #5 clk = ~clk;
	// run needs about 10k cycles; slow filter too long to wait for
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end
	function automatic logic [7:0] exp_rd(logic [2:0] o);
		return o == 3'h1 ? ~ins[7:0] : o == 3'h5 ? ~ins[15:8] : 8'hff;
	endfunction
	task automatic cmp(string nm, logic [10:0] e, logic [10:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// input filter settles after 1000 cycles plus sync
	task automatic flip(logic [15:0] m, logic [10:0] e);
		ins <= ins ^ m;
		repeat (1100) @(posedge clk);
		#1;
		cmp("irq", e, irq);
	endtask
	// clear lands at the edge that takes the write; checked one edge later
	task automatic wr_chk(logic [2:0] o, logic [10:0] e);
		host_u.acc({base, o}, 1'b1);
		@(posedge clk);
		#1;
		cmp("irq after write", e, irq);
	endtask
	task automatic results();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hc4e9588d));
		sel <= 11'h001 << ($urandom % 11);
		base <= 7'($urandom);
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		for (int r = 0; r < 4; r++) begin
			ins <= (r == 0) ? 16'h8001 : 16'($urandom);
			repeat (1100) @(posedge clk);
			for (int o = 0; o < 8; o++) begin
				host_u.acc({base, o[2:0]}, 1'b0);
				cmp("data", {3'h0, exp_rd(o[2:0])}, {3'h0, data});
				cmp("drive", 11'h001, {10'h000, oe});
			end
			host_u.acc({~base, 3'h1}, 1'b0);
			cmp("foreign", 11'h000, {10'h000, oe});
		end
		wr_chk(3'h1, 11'h000);
		flip(16'hffff, sel);
		wr_chk(3'h5, sel);
		wr_chk(3'h3, sel);
		wr_chk(3'h1, 11'h000);
		flip(16'h0008, sel);
		wr_chk(3'h2, 11'h000);
		flip(16'h0100, 11'h000);
		host_u.acc({base, 3'h2}, 1'b0);
		flip(16'h8000, sel);
		wr_chk(3'h1, 11'h000);
		slow <= 16'h0010;
		flip(16'h0010, 11'h000);
		results();
	end
endmodule // iso_input_port_test
`default_nettype wire
